// ===== rtl/spi_eeprom_protect_rw_core.sv
`timescale 1ns/1ps
`include "spi_eeprom_cfg.svh"
module spi_eeprom_protect_rw_core #(
	parameter int ADDR_W = `ADDR_BITS,
	parameter int PAGE_W = `PAGE_BITS,
	parameter int WC_CYCLES = `WC_CYCLES
) (
	// System
	input wire logic clock,
	input wire logic rstn,
	// Serial link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// Write guard pin
	input wire logic write_guard_pin_n
);
	localparam int DEPTH = 1 << ADDR_W;
	localparam int PAGE_N = 1 << PAGE_W;
	localparam int BASE_W = ADDR_W - PAGE_W;

	////////////////////////////////////////////////////////////////////////////////
	// Shared signals
	////////////////////////////////////////////////////////////////////////////////
	logic [7:0] protect_and_state_reg;
	logic [7:0] stat_l;
	logic [7:0] rd_byte;
	logic [ADDR_W-1:0] rd_addr;
	logic [7:0] mem_r [DEPTH];
	logic busy_flag;
	logic prog_done;
	logic prog_start;

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: runs on sck, frame state cleared while chip select is high
	////////////////////////////////////////////////////////////////////////////////
	wire frame_rst_n = rstn & ~cs_n;
	logic [2:0] bit_cnt_r;
	logic [6:0] sh_r;
	logic [1:0] idx_r;
	logic [7:0] ahi_r;
	logic [ADDR_W-1:0] addr_r;
	spi_eeprom_pkg::link_op_t op_r;
	spi_eeprom_pkg::link_op_t dec_op;
	logic tx_on_r;
	logic [7:0] tx_word_r;
	logic [7:0] out_sh_r;
	logic oe_r;
	logic partial_r;
	logic ev_fire;
	spi_eeprom_pkg::ev_kind_t ev_kind_nxt;
	spi_eeprom_pkg::ev_kind_t ev_kind_r;
	logic [7:0] ev_data_r;
	logic [ADDR_W-1:0] ev_addr_r;
	logic ev_tgl_r;

	wire byte_done = (bit_cnt_r == 3'h7);
	wire [7:0] byte_v = {sh_r, si};

	function automatic spi_eeprom_pkg::link_op_t op_decode(input logic [7:0] b);
		logic [7:0] m;
		m = b & `OPC_MASK;
		unique case (m)
			`OP_SET: return spi_eeprom_pkg::op_set;
			`OP_CLR: return spi_eeprom_pkg::op_clr;
			`OP_RDS: return spi_eeprom_pkg::op_rds;
			`OP_WRS: return spi_eeprom_pkg::op_wrs;
			`OP_RD: return spi_eeprom_pkg::op_rd;
			`OP_WR: return spi_eeprom_pkg::op_wr;
			default: return spi_eeprom_pkg::op_none;
		endcase
	endfunction

	assign dec_op = op_decode(byte_v);

	// Address of the byte to fetch next: the fresh address, or the current one plus one
	always_comb begin
		if (idx_r == 2'h2) begin
			rd_addr = {ahi_r[ADDR_W-9:0], byte_v};
		end else begin
			rd_addr = addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
		end
	end

	// Shift in on the rising edge, first bit is the most significant
	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt_r <= 3'h0;
			sh_r <= 7'h00;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			sh_r <= byte_v[6:0];
		end
	end

	// Byte position, command and address
	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			idx_r <= 2'h0;
			op_r <= spi_eeprom_pkg::op_none;
			ahi_r <= 8'h00;
			addr_r <= '0;
		end else if (byte_done) begin
			if (idx_r != 2'h3) begin
				idx_r <= idx_r + 2'h1;
			end
			if (idx_r == 2'h0) begin
				op_r <= dec_op;
			end
			if (idx_r == 2'h1) begin
				ahi_r <= byte_v;
			end
			if ((idx_r == 2'h2) || (op_r == spi_eeprom_pkg::op_rd)) begin
				addr_r <= rd_addr;
			end
		end
	end

	// Word to send next; reads stay silent while programming
	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			tx_on_r <= 1'b0;
			tx_word_r <= 8'h00;
		end else if (byte_done) begin
			if (idx_r == 2'h0) begin
				tx_on_r <= (dec_op == spi_eeprom_pkg::op_rds);
				tx_word_r <= stat_l;
			end else if (op_r == spi_eeprom_pkg::op_rds) begin
				tx_word_r <= stat_l;
			end else if ((op_r == spi_eeprom_pkg::op_rd) && (idx_r != 2'h1)) begin
				tx_on_r <= !stat_l[`ST_BUSY];
				tx_word_r <= rd_byte;
			end
		end
	end

	// Output shifts after the falling edge; not driven outside a frame
	always_ff @(negedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			out_sh_r <= 8'h00;
			oe_r <= 1'b0;
		end else begin
			if ((bit_cnt_r == 3'h0) && tx_on_r) begin
				out_sh_r <= tx_word_r;
			end else begin
				out_sh_r <= {out_sh_r[6:0], 1'b0};
			end
			oe_r <= tx_on_r;
		end
	end

	assign so = out_sh_r[7];
	assign so_oe = oe_r;

	// Marks a frame that ended between byte boundaries; survives chip select rising
	always_ff @(posedge sck or negedge rstn) begin
		if (!rstn) begin
			partial_r <= 1'b0;
		end else begin
			partial_r <= !byte_done;
		end
	end

	// Events for the core
	always_comb begin
		ev_fire = 1'b0;
		ev_kind_nxt = spi_eeprom_pkg::ev_set;
		if (byte_done) begin
			if ((idx_r == 2'h0) && (dec_op == spi_eeprom_pkg::op_set)) begin
				ev_fire = 1'b1;
			end else if ((idx_r == 2'h0) && (dec_op == spi_eeprom_pkg::op_clr)) begin
				ev_fire = 1'b1;
				ev_kind_nxt = spi_eeprom_pkg::ev_clr;
			end else if ((idx_r == 2'h1) && (op_r == spi_eeprom_pkg::op_wrs)) begin
				ev_fire = 1'b1;
				ev_kind_nxt = spi_eeprom_pkg::ev_sdata;
			end else if ((idx_r == 2'h2) && (op_r == spi_eeprom_pkg::op_wr)) begin
				ev_fire = 1'b1;
				ev_kind_nxt = spi_eeprom_pkg::ev_wstart;
			end else if ((idx_r == 2'h3) && (op_r == spi_eeprom_pkg::op_wr)) begin
				ev_fire = 1'b1;
				ev_kind_nxt = spi_eeprom_pkg::ev_wdata;
			end
		end
	end

	// Fields stay put until the next event, a byte time later; the toggle announces them
	always_ff @(posedge sck or negedge rstn) begin
		if (!rstn) begin
			ev_kind_r <= spi_eeprom_pkg::ev_set;
			ev_data_r <= 8'h00;
			ev_addr_r <= '0;
			ev_tgl_r <= 1'b0;
		end else if (ev_fire) begin
			ev_kind_r <= ev_kind_nxt;
			ev_data_r <= byte_v;
			ev_addr_r <= rd_addr;
			ev_tgl_r <= ~ev_tgl_r;
		end
	end

	bit_sync #(.W(8)) u_stat_sync (
		.clock(sck),
		.rstn(rstn),
		.d(protect_and_state_reg),
		.q(stat_l)
	);

	a_read_wrap: assert property (@(posedge sck) disable iff (!frame_rst_n)
		(op_r == spi_eeprom_pkg::op_rd) && (idx_r == 2'h3) && byte_done && (addr_r == '1) |=> (addr_r == '0))
		else $error("read address did not wrap to zero");

	////////////////////////////////////////////////////////////////////////////////
	// Core domain
	////////////////////////////////////////////////////////////////////////////////
	logic cs_s;
	logic wp_s;
	logic part_s;
	logic ev_tgl_s;
	logic ev_seen_r;
	logic cs_d_r;
	logic write_latch_flag_r;
	logic pin_guard_enable_r = 1'(`NV_INIT >> 2);
	logic block_guard_hi_r = 1'(`NV_INIT >> 1);
	logic block_guard_lo_r = 1'(`NV_INIT);
	logic wr_arm_r;
	logic st_arm_r;
	logic wr_cmt_r;
	logic st_cmt_r;
	logic [BASE_W-1:0] base_r;
	logic [PAGE_W-1:0] ptr_r;
	logic [PAGE_N-1:0] valid_r;
	logic [7:0] st_data_r;
	logic [7:0] page_r [PAGE_N];
	logic [31:0] run_len_r;

	bit_sync #(.W(3)) u_pin_sync (
		.clock(clock),
		.rstn(rstn),
		.d({cs_n, write_guard_pin_n, partial_r}),
		.q({cs_s, wp_s, part_s})
	);

	bit_sync #(.W(1)) u_ev_sync (
		.clock(clock),
		.rstn(rstn),
		.d(ev_tgl_r),
		.q(ev_tgl_s)
	);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ev_seen_r <= 1'b0;
			// Idle level of chip select; cs_s still resets low, so one false frame end follows reset
			cs_d_r <= 1'b1;
		end else begin
			ev_seen_r <= ev_tgl_s;
			cs_d_r <= cs_s;
		end
	end

	wire ev_new = (ev_tgl_s ^ ev_seen_r) && !busy_flag;
	wire cs_rise = cs_s && !cs_d_r;
	wire hw_prot = !wp_s && pin_guard_enable_r;

	function automatic logic prot_hit(input logic [ADDR_W-1:0] a, input logic hi, input logic lo);
		unique case ({hi, lo})
			2'h0: return 1'b0;
			2'h1: return a >= `PROT_QUARTER;
			2'h2: return a >= `PROT_HALF;
			default: return 1'b1;
		endcase
	endfunction

	wire wstart_hit = prot_hit(ev_addr_r, block_guard_hi_r, block_guard_lo_r);

	// Write latch: off at power-up, cleared by command or by the end of programming
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			write_latch_flag_r <= 1'b0;
		end else if (prog_done) begin
			write_latch_flag_r <= 1'b0;
		end else if (ev_new && (ev_kind_r == spi_eeprom_pkg::ev_set)) begin
			write_latch_flag_r <= 1'b1;
		end else if (ev_new && (ev_kind_r == spi_eeprom_pkg::ev_clr)) begin
			write_latch_flag_r <= 1'b0;
		end
	end

	// Collect a page or a status byte during the frame
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_arm_r <= 1'b0;
			st_arm_r <= 1'b0;
			base_r <= '0;
			ptr_r <= '0;
			valid_r <= '0;
			st_data_r <= 8'h00;
		end else if (cs_rise) begin
			wr_arm_r <= 1'b0;
			st_arm_r <= 1'b0;
		end else if (ev_new) begin
			unique case (ev_kind_r)
				spi_eeprom_pkg::ev_wstart: begin
					wr_arm_r <= write_latch_flag_r && !wstart_hit;
					base_r <= ev_addr_r[ADDR_W-1:PAGE_W];
					ptr_r <= ev_addr_r[PAGE_W-1:0];
					valid_r <= '0;
				end
				spi_eeprom_pkg::ev_wdata: begin
					if (wr_arm_r) begin
						valid_r[ptr_r] <= 1'b1;
						ptr_r <= ptr_r + {{(PAGE_W-1){1'b0}}, 1'b1};
					end
				end
				spi_eeprom_pkg::ev_sdata: begin
					st_arm_r <= write_latch_flag_r;
					st_data_r <= ev_data_r;
				end
				spi_eeprom_pkg::ev_set, spi_eeprom_pkg::ev_clr: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (ev_new && wr_arm_r && (ev_kind_r == spi_eeprom_pkg::ev_wdata)) begin
			page_r[ptr_r] <= ev_data_r;
		end
	end

	// Programming begins only at frame end, on a byte boundary
	assign prog_start = cs_rise && !part_s && !busy_flag &&
		((wr_arm_r && (|valid_r)) || (st_arm_r && !hw_prot));

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_cmt_r <= 1'b0;
			st_cmt_r <= 1'b0;
		end else if (prog_start) begin
			wr_cmt_r <= wr_arm_r && (|valid_r);
			st_cmt_r <= st_arm_r && !hw_prot;
		end
	end

	wc_timer #(.CYCLES(WC_CYCLES)) u_timer (
		.clock(clock),
		.rstn(rstn),
		.start(prog_start),
		.busy(busy_flag),
		.done(prog_done)
	);

	// Array cells and guard bits keep their contents through reset
	always_ff @(posedge clock) begin
		if (prog_done && wr_cmt_r) begin
			for (int i = 0; i < PAGE_N; i++) begin
				if (valid_r[i]) begin
					mem_r[{base_r, PAGE_W'(i)}] <= page_r[i];
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (prog_done && st_cmt_r) begin
			pin_guard_enable_r <= st_data_r[`ST_PGE];
			block_guard_hi_r <= st_data_r[`ST_BG_HI];
			block_guard_lo_r <= st_data_r[`ST_BG_LO];
		end
	end

	// Array contents change only when programming ends, while reads are still silent, so the link reads them directly
	assign rd_byte = mem_r[rd_addr];

	always_comb begin
		protect_and_state_reg = 8'h00;
		if (busy_flag) begin
			protect_and_state_reg = `ST_BUSY_WORD;
		end else begin
			protect_and_state_reg[`ST_LATCH] = write_latch_flag_r;
			protect_and_state_reg[`ST_BG_LO] = block_guard_lo_r;
			protect_and_state_reg[`ST_BG_HI] = block_guard_hi_r;
			protect_and_state_reg[`ST_PGE] = pin_guard_enable_r;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			run_len_r <= 32'h0000_0000;
		end else if (prog_start) begin
			run_len_r <= 32'h0000_0000;
		end else if (busy_flag) begin
			run_len_r <= run_len_r + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	////////////////////////////////////////////////////////////////////////////////
	a_clr_latch: assert property (@(posedge clock) disable iff (!rstn)
		ev_new && (ev_kind_r == spi_eeprom_pkg::ev_clr) |=> !write_latch_flag_r)
		else $error("clear command left the write latch set");

	a_busy_word: assert property (@(posedge clock) disable iff (!rstn)
		busy_flag |-> (protect_and_state_reg == `ST_BUSY_WORD))
		else $error("status not all ones while programming");

	a_idle_word: assert property (@(posedge clock) disable iff (!rstn)
		!busy_flag |-> (protect_and_state_reg[6:4] == 3'h0) && !protect_and_state_reg[`ST_BUSY] &&
		(protect_and_state_reg[`ST_LATCH] == write_latch_flag_r))
		else $error("idle status word malformed");

	a_pin_lock: assert property (@(posedge clock) disable iff (!rstn)
		pin_guard_enable_r && !wp_s && !busy_flag && $stable(wp_s) |=> pin_guard_enable_r)
		else $error("pin guard enable cleared while guard pin low");

	a_guard_refuse: assert property (@(posedge clock) disable iff (!rstn)
		prog_start && hw_prot |=> !st_cmt_r)
		else $error("status write accepted under hardware protection");

	a_block_refuse: assert property (@(posedge clock) disable iff (!rstn)
		ev_new && (ev_kind_r == spi_eeprom_pkg::ev_wstart) && (wstart_hit || !write_latch_flag_r) |=> !wr_arm_r)
		else $error("protected or unlatched write was armed");

	a_page_wrap: assert property (@(posedge clock) disable iff (!rstn)
		ev_new && wr_arm_r && (ev_kind_r == spi_eeprom_pkg::ev_wdata) && (ptr_r == '1) |=> (ptr_r == '0))
		else $error("page pointer did not wrap");

	a_start_cs: assert property (@(posedge clock) disable iff (!rstn)
		$rose(busy_flag) |-> $past(cs_rise))
		else $error("programming began without chip select rising");

	a_busy_len: assert property (@(posedge clock) disable iff (!rstn)
		$fell(busy_flag) |-> (run_len_r == WC_CYCLES))
		else $error("programming time wrong");

	a_latch_auto: assert property (@(posedge clock) disable iff (!rstn)
		$fell(busy_flag) |-> !write_latch_flag_r)
		else $error("write latch still set after programming");

	a_out_quiet: assert property (@(posedge clock) disable iff (!rstn)
		cs_n |-> !so_oe)
		else $error("output driven while deselected");
endmodule

// ===== rtl/spi_eeprom_cfg.svh
`ifndef SPI_EEPROM_CFG_SVH
`define SPI_EEPROM_CFG_SVH
`define ADDR_BITS 13
`define PAGE_BITS 5
`define OPC_MASK 8'hF7
`define OP_SET 8'h06
`define OP_CLR 8'h04
`define OP_RDS 8'h05
`define OP_WRS 8'h01
`define OP_RD 8'h03
`define OP_WR 8'h02
`define ST_BUSY 0
`define ST_LATCH 1
`define ST_BG_LO 2
`define ST_BG_HI 3
`define ST_PGE 7
`define ST_BUSY_WORD 8'hFF
`define PROT_QUARTER 13'h1800
`define PROT_HALF 13'h1000
`define NV_INIT 3'h0
`define CLK_PERIOD_NS 4
`define WC_TIME_NS 5000000
`define WC_CYCLES (`WC_TIME_NS / `CLK_PERIOD_NS)
`endif

// ===== rtl/spi_eeprom_pkg.sv
package spi_eeprom_pkg;
	// Command held for the rest of a frame
	typedef enum logic [6:0] {
		op_none = 7'h01,
		op_set = 7'h02,
		op_clr = 7'h04,
		op_rds = 7'h08,
		op_wrs = 7'h10,
		op_rd = 7'h20,
		op_wr = 7'h40
	} link_op_t;
	// Events handed from the link to the core
	typedef enum logic [4:0] {
		ev_set = 5'h01,
		ev_clr = 5'h02,
		ev_wstart = 5'h04,
		ev_wdata = 5'h08,
		ev_sdata = 5'h10
	} ev_kind_t;
endpackage

// ===== rtl/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
	parameter int W = 1
) (
	// Destination clock
	input wire logic clock,
	input wire logic rstn,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// ===== rtl/wc_timer.sv
`timescale 1ns/1ps
module wc_timer #(
	parameter int CYCLES = 8
) (
	// System
	input wire logic clock,
	input wire logic rstn,
	// Control
	input wire logic start,
	output logic busy,
	output logic done
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_r;

	assign done = busy && (cnt_r == '0);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			busy <= 1'b0;
			cnt_r <= '0;
		end else if (start && !busy) begin
			busy <= 1'b1;
			cnt_r <= CW'(CYCLES - 1);
		end else if (done) begin
			busy <= 1'b0;
		end else if (busy) begin
			cnt_r <= cnt_r - CW'(1);
		end
	end
endmodule

// ===== tb/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
	// Serial link
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	logic oe_seen;
	logic [7:0] rx [$];

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		oe_seen = 1'b0;
	end

	always @(posedge so_oe) begin
		oe_seen = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// One framed transfer; cut drops trailing bits to abort mid-byte
	task automatic frame(input logic [7:0] tx [$], input int nrx = 0, input int cut = 0);
		int n;
		logic [7:0] b;
		n = (tx.size() + nrx) * 8 - cut;
		rx = {};
		b = 8'h00;
		oe_seen = 1'b0;
		#3.3 cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			if (i < tx.size() * 8) begin
				si = tx[i / 8][7 - i % 8];
			end else begin
				si = ~si;
			end
			#16 sck = 1'b1;
			b = {b[6:0], so};
			if (i >= tx.size() * 8 && i % 8 == 7) begin
				rx.push_back(b);
			end
			#16 sck = 1'b0;
		end
		#8 cs_n = 1'b1;
		si = ~si;
		#40;
	endtask
endmodule

// ===== tb/spi_eeprom_protect_rw_core_tb.sv
`timescale 1ns/1ps
module spi_eeprom_protect_rw_core_tb;
	typedef struct packed {
		logic [1:0] bp;
		logic [15:0] a;
		logic ok;
	} row_t;
	localparam int LIMIT = 80000;
	logic clock;
	logic rstn;
	logic sck;
	logic cs_n;
	logic si;
	logic so;
	logic so_oe;
	logic write_guard_pin_n;
	int n_fail;
	int num_checks;
	int cycles;
	row_t rows [7];
	logic [7:0] q [$];

	spi_eeprom_protect_rw_core #(.WC_CYCLES(600)) dut (.clock(clock), .rstn(rstn), .sck(sck), .cs_n(cs_n),
		.si(si), .so(so), .so_oe(so_oe), .write_guard_pin_n(write_guard_pin_n));
	spi_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

	always #2 clock = ~clock;

	always @(posedge clock) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_fail++;
			$display("mismatch at %0t: timeout", $time);
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic read_state_cmd(input logic [7:0] exp);
		host.frame({8'h05}, 1);
		chk(host.rx[0], exp, "status");
	endtask

	// Poll until the program cycle ends
	task automatic ready();
		int k;
		k = 0;
		do begin
			host.frame({8'h05}, 1);
			k++;
		end while (host.rx[0][0] !== 1'b0 && k < 40);
		chk({7'h00, host.rx[0][0]}, 8'h00, "ready");
	endtask

	task automatic write_state_cmd(input logic [7:0] v);
		host.frame({8'h06});
		host.frame({8'h01, v});
		ready();
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		host.frame({8'h06});
		host.frame({8'h02, a[15:8], a[7:0], d});
		ready();
	endtask

	task automatic rd(input logic [15:0] a, input int n);
		host.frame({8'h03, a[15:8], a[7:0]}, n);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		write_guard_pin_n = 1'b1;
		n_fail = 0;
		num_checks = 0;
		cycles = 0;
		rows = '{'{2'h0, 16'h1fff, 1'b1}, '{2'h1, 16'h17ff, 1'b1}, '{2'h1, 16'h1800, 1'b0},
			'{2'h2, 16'h0fff, 1'b1}, '{2'h2, 16'h1000, 1'b0}, '{2'h3, 16'h0000, 1'b0}, '{2'h3, 16'h1c00, 1'b0}};
		repeat (20) @(negedge clock);
		rstn = 1'b1;
		repeat (5) @(negedge clock);
		read_state_cmd(8'h00);
		write_state_cmd(8'h00);
		foreach (rows[i]) wr(rows[i].a, 8'h5a);
		foreach (rows[i]) begin
			write_state_cmd({4'h0, rows[i].bp, 2'b00});
			read_state_cmd({4'h0, rows[i].bp, 2'b00});
			wr(rows[i].a, 8'ha0 + 8'(i));
			rd(rows[i].a, 1);
			chk(host.rx[0], rows[i].ok ? 8'ha0 + 8'(i) : 8'h5a, "guard");
		end
		write_state_cmd(8'h00);
		// Page write that wraps, commands issued while busy
		host.frame({8'h06});
		read_state_cmd(8'h02);
		q = {8'h02, 8'h00, 8'h40};
		for (int i = 0; i < 33; i++) q.push_back(8'h10 + 8'(i));
		host.frame(q);
		read_state_cmd(8'hff);
		host.frame({8'h06});
		rd(16'h0000, 1);
		chk({7'h00, host.oe_seen}, 8'h00, "busy read");
		ready();
		read_state_cmd(8'h00);
		rd(16'h0040, 32);
		for (int i = 0; i < 32; i++) chk(host.rx[i], 8'h10 + 8'(i == 0 ? 32 : i), "page");
		rd(16'hffff, 2);
		chk(host.rx[0], 8'ha0, "top");
		chk(host.rx[1], 8'h5a, "wrap");
		// Write without latch, then a write cut short
		host.frame({8'h02, 8'h00, 8'h41, 8'hee});
		read_state_cmd(8'h00);
		rd(16'h0041, 1);
		chk(host.rx[0], 8'h11, "no latch");
		host.frame({8'h06});
		host.frame({8'h02, 8'h00, 8'h42, 8'hee}, 0, 3);
		read_state_cmd(8'h02);
		host.frame({8'h04});
		read_state_cmd(8'h00);
		rd(16'h0042, 1);
		chk(host.rx[0], 8'h12, "cut");
		// Guard pin with pin guard enable set
		write_state_cmd(8'h84);
		@(negedge clock);
		write_guard_pin_n = 1'b0;
		repeat (4) @(negedge clock);
		host.frame({8'h0e});
		read_state_cmd(8'h86);
		host.frame({8'h0c});
		read_state_cmd(8'h84);
		write_state_cmd(8'h00);
		host.frame({8'h04});
		read_state_cmd(8'h84);
		wr(16'h0043, 8'h77);
		rd(16'h0043, 1);
		chk(host.rx[0], 8'h77, "unguarded");
		@(negedge clock);
		write_guard_pin_n = 1'b1;
		repeat (4) @(negedge clock);
		write_state_cmd(8'hfe);
		read_state_cmd(8'h8c);
		// Reset in mid-run keeps the guard bits
		host.frame({8'h06});
		@(negedge clock);
		rstn = 1'b0;
		repeat (20) @(negedge clock);
		rstn = 1'b1;
		repeat (5) @(negedge clock);
		host.frame({8'h0d}, 1);
		chk(host.rx[0], 8'h8c, "kept");
		chk({7'h00, so_oe}, 8'h00, "idle");
		end_sim();
	end
endmodule
